//--- ivas_vector_select.sv
`timescale 1ns/10ps
module ivas_vector_select
	import ivas_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// control
	input wire logic alt_table_select,
	// vector request from the core
	input wire ivas_req_t req,
	input wire logic [IVAS_NUM_SRC-1:0] pending,
	// answer
	output ivas_ans_t ans,
	output logic ans_ready,
	output logic [IVAS_VEC_W-1:0] win_vec,
	output logic win_valid,
	output logic [IVAS_ADDR_W-1:0] slot_addr,
	output logic [IVAS_ADDR_W-1:0] start_pc
);
	// ****************************************
	// decoding
	// ****************************************
	// slot address of vector v in either table; the alternate table is the primary
	// one moved up, so one adder serves both
	function automatic logic [IVAS_ADDR_W-1:0] slot_of(input logic alt,
		input logic [IVAS_VEC_W-1:0] v);
		logic [IVAS_ADDR_W-1:0] base;
		base = alt ? IVAS_ALT_BASE : IVAS_PRIMARY_BASE; // see R1 see R2
		slot_of = base + {{(IVAS_ADDR_W-IVAS_VEC_W-1){1'b0}}, v, 1'b0}; // see R11 see R4 see R5
	endfunction

	// request number of an interrupt vector; only meaningful at or above the offset
	function automatic logic [IVAS_VEC_W-1:0] irq_of(
		input logic [IVAS_VEC_W-1:0] v
	);
		irq_of = v - IVAS_IRQ_OFFSET; // see R5
	endfunction

	// trap slots that have a source behind them
	function automatic logic trap_named(
		input logic [IVAS_VEC_W-1:0] v
	);
		case (v)
			IVAS_TRAP_OSC_FAIL: trap_named = 1'b1; // see R4
			IVAS_TRAP_ADDR_ERROR: trap_named = 1'b1; // see R4
			IVAS_TRAP_STACK_ERROR: trap_named = 1'b1; // see R4
			IVAS_TRAP_MATH_ERROR: trap_named = 1'b1; // see R4
			default: trap_named = 1'b0; // see R4
		endcase
	endfunction

	// request numbers that have a source behind them
	function automatic logic irq_named(
		input logic [IVAS_VEC_W-1:0] irq
	);
		case (irq)
			IVAS_IRQ_EXT_ZERO: irq_named = 1'b1; // see R6
			IVAS_IRQ_CAPTURE_ONE: irq_named = 1'b1; // see R6
			IVAS_IRQ_COMPARE_ONE: irq_named = 1'b1; // see R6
			IVAS_IRQ_TIMER_ONE: irq_named = 1'b1; // see R6
			IVAS_IRQ_CAPTURE_TWO: irq_named = 1'b1; // see R6
			IVAS_IRQ_COMPARE_TWO: irq_named = 1'b1; // see R6
			IVAS_IRQ_TIMER_TWO: irq_named = 1'b1; // see R6
			IVAS_IRQ_TIMER_THREE: irq_named = 1'b1; // see R6
			IVAS_IRQ_SPI_ERROR: irq_named = 1'b1; // see R7
			IVAS_IRQ_SPI_DONE: irq_named = 1'b1; // see R7
			IVAS_IRQ_UART_RX: irq_named = 1'b1; // see R7
			IVAS_IRQ_UART_TX: irq_named = 1'b1; // see R7
			IVAS_IRQ_CONVERTER: irq_named = 1'b1; // see R7
			IVAS_IRQ_TW_SLAVE: irq_named = 1'b1; // see R8
			IVAS_IRQ_TW_MASTER: irq_named = 1'b1; // see R8
			IVAS_IRQ_CHANGE_NOTE: irq_named = 1'b1; // see R8
			IVAS_IRQ_EXT_ONE: irq_named = 1'b1; // see R8
			IVAS_IRQ_CAPTURE_SEVEN: irq_named = 1'b1; // see R8
			IVAS_IRQ_CAPTURE_EIGHT: irq_named = 1'b1; // see R8
			IVAS_IRQ_EXT_TWO: irq_named = 1'b1; // see R8
			IVAS_IRQ_UART_ERROR: irq_named = 1'b1; // see R8
			default: irq_named = 1'b0; // see R6 see R7 see R8
		endcase
	endfunction

	// reserved slots still get an address; the flag only warns the core that no
	// source can raise them, so a hit there points at a fault elsewhere
	function automatic logic is_reserved(
		input logic [IVAS_VEC_W-1:0] v
	);
		if (v < IVAS_IRQ_OFFSET) begin
			is_reserved = !trap_named(v); // see R4
		end else begin
			is_reserved = !irq_named(irq_of(v)); // see R6 see R7 see R8
		end
	endfunction

	// ****************************************
	// vector tables
	// ****************************************
	// both tables are constants built slot by slot, so the alternate table keeps the
	// primary order by construction; synthesis folds them into wiring
	logic [IVAS_ADDR_W-1:0] primary_vector_table [IVAS_NUM_SRC];
	logic [IVAS_ADDR_W-1:0] alternate_vector_table [IVAS_NUM_SRC];
	logic [IVAS_NUM_SRC-1:0] src_reserved;
	logic [IVAS_NUM_SRC-1:0] src_is_trap;

	generate
		for (genvar g = 0; g < IVAS_NUM_SRC; g++) begin : g_table
			localparam logic [IVAS_VEC_W-1:0] SLOT_VEC = IVAS_VEC_W'(g);
			assign primary_vector_table[g] = slot_of(1'b0, SLOT_VEC); // see R2
			assign alternate_vector_table[g] = slot_of(1'b1, SLOT_VEC); // see R2
			assign src_reserved[g] = is_reserved(SLOT_VEC);
			assign src_is_trap[g] = SLOT_VEC < IVAS_IRQ_OFFSET; // see R4
		end
	endgenerate

	// ****************************************
	// natural priority
	// ****************************************
	// a slot wins when nothing below it is pending, which leaves at most one hit;
	// each slot looks at all lower ones directly, so no ripple chain forms
	logic [IVAS_NUM_SRC-1:0] lower_pending;
	logic [IVAS_NUM_SRC-1:0] first_hit;

	generate
		for (genvar g = 0; g < IVAS_NUM_SRC; g++) begin : g_prio
			if (g == 0) begin : g_bottom
				assign lower_pending[g] = 1'b0;
			end else begin : g_above
				assign lower_pending[g] = |pending[g-1:0];
			end
			assign first_hit[g] = pending[g] & ~lower_pending[g]; // see R9
		end
	endgenerate

	// one-hot to binary: each winner bit is the or of the hits whose number has it
	generate
		for (genvar b = 0; b < IVAS_VEC_W; b++) begin : g_enc
			logic [IVAS_NUM_SRC-1:0] has_bit;
			for (genvar g = 0; g < IVAS_NUM_SRC; g++) begin : g_src
				if (((g >> b) % 2) == 1) begin : g_on
					assign has_bit[g] = first_hit[g];
				end else begin : g_off
					assign has_bit[g] = 1'b0;
				end
			end
			assign win_vec[b] = |has_bit;
		end
	endgenerate

	assign win_valid = |pending; // see R9

	// ****************************************
	// acceptance
	// ****************************************
	logic taken;

	// numbers above the last vector are not slots; they are dropped, not answered,
	// so a stray number from the core never reaches ans, though slot_addr still points outside both tables for it
	assign taken = req.valid && req.vec <= IVAS_LAST_VEC; // see R5
	// combinational slot address in the acceptance cycle; the registered copy follows
	assign slot_addr = slot_of(alt_table_select, req.vec); // see R11
	// the table lookup never stalls, so the core is never held off
	assign ans_ready = 1'b1;

	// ****************************************
	// answer
	// ****************************************
	// the select bit is taken at the request edge, so a switch never splits a fetch
	ivas_ans_t fetch_ans;

	// fields are only copied on a taken request, so these zeros never reach the port
	always_comb begin
		fetch_ans = '0;
		fetch_ans.valid = taken; // see R11
		fetch_ans.vec = req.vec;
		fetch_ans.alt = alt_table_select; // see R1
		if (taken) begin
			fetch_ans.is_trap = src_is_trap[req.vec]; // see R4
			fetch_ans.reserved = src_reserved[req.vec]; // see R6 see R7 see R8
			if (alt_table_select) begin
				fetch_ans.addr = alternate_vector_table[req.vec]; // see R1 see R10
			end else begin
				fetch_ans.addr = primary_vector_table[req.vec]; // see R10
			end
		end
	end

	// ****************************************
	// state
	// ****************************************
	ivas_state_t state_reg;
	ivas_state_t state_next;

	// the answer pulses for one cycle; its other fields hold until the next request
	always_comb begin
		state_next = state_reg;
		state_next.ans.valid = 1'b0;
		if (fetch_ans.valid) begin
			state_next.ans = fetch_ans;
		end
	end

	// ****************************************
	// reset
	// ****************************************
	// the controller has no say at reset: the core starts from address zero,
	// whatever table the select bit named before
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= '{ans: '0, pc: IVAS_RESET_ADDR}; // see R3
		end else begin
			state_reg <= state_next;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	// start_pc never moves: the core loads it only when it leaves reset
	assign ans = state_reg.ans;
	assign start_pc = state_reg.pc; // see R3
endmodule

//--- ivas_pkg.sv
// Behaviour
// R1 - alternate-table select bit set: every vector from alternate table, else primary table
// R2 - alternate table follows primary table with identical slot order
// R3 - reset bypasses controller; registers clear, program counter forced to zero
// R4 - traps 0..7 at primary 0x000004.. and alternate 0x000104..; 1-4 named traps
// R5 - vectors 8..125 map to requests 0..117; slots from 0x000014 / 0x000114
// R6 - requests 0-8: ext0, capture1, compare1, timer1, reserved, capture2, compare2, timers
// R7 - requests 9-13: serial error, serial done, uart rx, uart tx, converter; 14,15 reserved
// R8 - requests 16,17,19,20,22,23,29,65 named; all others up to 117 reserved
// R9 - lower vector address has higher natural priority; vector 0 outranks all
// R10 - each slot holds a 24-bit program address loaded as handler start
// R11 - slot address equals selected base plus twice vector number, same cycle
package ivas_pkg;
	// ****************************************
	// widths and addresses
	// ****************************************
	localparam int IVAS_ADDR_W = 24;
	localparam int IVAS_VEC_W = 7;
	localparam int IVAS_NUM_SRC = 126;
	localparam int IVAS_NUM_TRAP = 8;
	localparam logic [IVAS_ADDR_W-1:0] IVAS_RESET_ADDR = 24'h000000;
	localparam logic [IVAS_ADDR_W-1:0] IVAS_PRIMARY_BASE = 24'h000004;
	localparam logic [IVAS_ADDR_W-1:0] IVAS_ALT_BASE = 24'h000104;
	localparam logic [IVAS_VEC_W-1:0] IVAS_LAST_VEC = 7'h7d;
	localparam logic [IVAS_VEC_W-1:0] IVAS_IRQ_OFFSET = 7'h08;
	// ****************************************
	// trap vectors with a source behind them
	// ****************************************
	localparam logic [IVAS_VEC_W-1:0] IVAS_TRAP_OSC_FAIL = 7'h01;
	localparam logic [IVAS_VEC_W-1:0] IVAS_TRAP_ADDR_ERROR = 7'h02;
	localparam logic [IVAS_VEC_W-1:0] IVAS_TRAP_STACK_ERROR = 7'h03;
	localparam logic [IVAS_VEC_W-1:0] IVAS_TRAP_MATH_ERROR = 7'h04;
	// ****************************************
	// request numbers of named sources
	// ****************************************
	localparam logic [IVAS_VEC_W-1:0] IVAS_IRQ_EXT_ZERO = 7'h00;
	localparam logic [IVAS_VEC_W-1:0] IVAS_IRQ_CAPTURE_ONE = 7'h01;
	localparam logic [IVAS_VEC_W-1:0] IVAS_IRQ_COMPARE_ONE = 7'h02;
	localparam logic [IVAS_VEC_W-1:0] IVAS_IRQ_TIMER_ONE = 7'h03;
	localparam logic [IVAS_VEC_W-1:0] IVAS_IRQ_CAPTURE_TWO = 7'h05;
	localparam logic [IVAS_VEC_W-1:0] IVAS_IRQ_COMPARE_TWO = 7'h06;
	localparam logic [IVAS_VEC_W-1:0] IVAS_IRQ_TIMER_TWO = 7'h07;
	localparam logic [IVAS_VEC_W-1:0] IVAS_IRQ_TIMER_THREE = 7'h08;
	localparam logic [IVAS_VEC_W-1:0] IVAS_IRQ_SPI_ERROR = 7'h09;
	localparam logic [IVAS_VEC_W-1:0] IVAS_IRQ_SPI_DONE = 7'h0a;
	localparam logic [IVAS_VEC_W-1:0] IVAS_IRQ_UART_RX = 7'h0b;
	localparam logic [IVAS_VEC_W-1:0] IVAS_IRQ_UART_TX = 7'h0c;
	localparam logic [IVAS_VEC_W-1:0] IVAS_IRQ_CONVERTER = 7'h0d;
	localparam logic [IVAS_VEC_W-1:0] IVAS_IRQ_TW_SLAVE = 7'h10;
	localparam logic [IVAS_VEC_W-1:0] IVAS_IRQ_TW_MASTER = 7'h11;
	localparam logic [IVAS_VEC_W-1:0] IVAS_IRQ_CHANGE_NOTE = 7'h13;
	localparam logic [IVAS_VEC_W-1:0] IVAS_IRQ_EXT_ONE = 7'h14;
	localparam logic [IVAS_VEC_W-1:0] IVAS_IRQ_CAPTURE_SEVEN = 7'h16;
	localparam logic [IVAS_VEC_W-1:0] IVAS_IRQ_CAPTURE_EIGHT = 7'h17;
	localparam logic [IVAS_VEC_W-1:0] IVAS_IRQ_EXT_TWO = 7'h1d;
	localparam logic [IVAS_VEC_W-1:0] IVAS_IRQ_UART_ERROR = 7'h41;
	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic valid;
		logic [IVAS_VEC_W-1:0] vec;
	} ivas_req_t;
	typedef struct packed {
		logic valid;
		logic is_trap;
		logic reserved;
		logic alt;
		logic [IVAS_VEC_W-1:0] vec;
		logic [IVAS_ADDR_W-1:0] addr;
	} ivas_ans_t;
	typedef struct packed {
		ivas_ans_t ans;
		logic [IVAS_ADDR_W-1:0] pc;
	} ivas_state_t;
endpackage

//--- ivas_sva.sv
`timescale 1ns/10ps
module ivas_sva
	import ivas_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic alt_table_select,
	input wire ivas_req_t req,
	input wire logic [IVAS_NUM_SRC-1:0] pending,
	input wire ivas_ans_t ans,
	input wire logic ans_ready,
	input wire logic [IVAS_VEC_W-1:0] win_vec,
	input wire logic win_valid,
	input wire logic [IVAS_ADDR_W-1:0] slot_addr,
	input wire logic [IVAS_ADDR_W-1:0] start_pc
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	wire tk = req.valid && req.vec <= 7'h7d;
	a_slot_calc: assert property (tk |-> slot_addr ==
		(alt_table_select ? 24'h000104 : 24'h000004) + {req.vec, 1'b0}) else $error("slot");
	a_ans_pulse: assert property (tk |=> ans.valid) else $error("no ans");
	a_no_spurious: assert property (!tk |=> !ans.valid) else $error("spurious ans");
	a_ans_addr: assert property (tk |=> ans.addr == $past(slot_addr)) else $error("addr");
	a_alt_used: assert property (tk |=> ans.alt == $past(alt_table_select)) else $error("alt");
	a_trap_flag: assert property (ans.valid |-> ans.is_trap == (ans.vec < 7'h08))
		else $error("trap");
	a_start_zero: assert property (start_pc == 24'h000000 && ans_ready) else $error("pc");
	a_win_lowest: assert property (win_valid |-> pending[win_vec] &&
		!(|(pending & ((126'h1 << win_vec) - 126'h1)))) else $error("win");
	a_win_any: assert property (win_valid == (|pending)) else $error("win valid");
	cover property (ans.valid && ans.alt);
	cover property (ans.valid && ans.is_trap);
	cover property (win_valid && win_vec == 7'h7d);
endmodule
bind ivas_vector_select ivas_sva u_sva (.*);

//--- ivas_core.sv
`timescale 1ns/10ps
module ivas_core
	import ivas_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic go,
	input wire logic [IVAS_VEC_W-1:0] v,
	output ivas_req_t req
);
	// the number is meaningless outside a fetch, so it is scrambled there
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) req <= '0;
		else req <= '{go, go ? v : ~req.vec};
	end
endmodule

//--- tb.sv
`timescale 1ns/10ps
module tb;
	import ivas_pkg::*;
	logic clk = 0, rstn = 0, alt = 0, go = 0, wok, rdy;
	logic [IVAS_VEC_W-1:0] v = '0, wv;
	logic [IVAS_NUM_SRC-1:0] pnd = '0;
	logic [IVAS_ADDR_W-1:0] sa, pc;
	ivas_req_t req;
	ivas_ans_t ans;
	int n_errors = 0, num_checks = 0;
	initial forever #25 clk = ~clk;
	ivas_core core (.clk(clk), .rstn(rstn), .go(go), .v(v), .req(req));
	ivas_vector_select dut (.clk(clk), .rstn(rstn), .alt_table_select(alt), .req(req),
		.pending(pnd), .ans(ans), .ans_ready(rdy), .win_vec(wv), .win_valid(wok),
		.slot_addr(sa), .start_pc(pc));
	task chk(string s, logic [39:0] e, logic [39:0] g);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s exp %h got %h", s, e, g);
		end
	endtask
	function logic rsv(int k);
		if (k < 8) return !(k inside {[1:4]});
		return !((k - 8) inside {[0:3], [5:13], 16, 17, 19, 20, 22, 23, 29, 65});
	endfunction
	task fetch(int k, logic a);
		logic [23:0] e;
		e = (a ? 24'h000104 : 24'h000004) + 24'(2 * k);
		@(posedge clk);
		go <= k < 128;
		v <= 7'(k);
		alt <= a;
		@(posedge clk);
		go <= 0;
		#1 if (k < 126) chk("slot", e, sa);
		@(posedge clk);
		#1 if (k > 125) chk("refused", 0, ans.valid);
		else chk("ans", {1'b1, k < 8, rsv(k), a, 7'(k), e}, ans);
	endtask
	task prio(int lo, int hi);
		@(posedge clk);
		pnd <= (126'h1 << lo) | (126'h1 << hi);
		#1 chk("win", {1'b1, 7'(lo)}, {wok, wv});
	endtask
	task test_done;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task test_tables;
		for (int k = 0; k < 256; k++) fetch(k % 128, k > 127);
		chk("ready", 1, rdy);
		$display("vector tables done");
	endtask
	task test_priority;
		prio(3, 70);
		prio(0, 125);
		prio(125, 125);
		@(posedge clk);
		pnd <= '0;
		#1 chk("idle", 0, wok);
		$display("priority done");
	endtask
	task test_reset;
		@(posedge clk);
		go <= 1;
		v <= 7'h10;
		alt <= 1;
		@(posedge clk);
		go <= 0;
		@(posedge clk);
		rstn <= 0;
		#1 chk("reset ans", 0, ans);
		chk("reset pc", 0, pc);
		@(posedge clk);
		rstn <= 1;
		fetch(8, 0);
		$display("reset done");
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rstn <= 1;
		test_tables;
		test_priority;
		test_reset;
		test_done;
	end
endmodule
